// ==== hdl/dcff_cfg.svh ====
`ifndef DCFF_CFG_SVH
`define DCFF_CFG_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define DCFF_DATA_W 18
`define DCFF_ADDR_W 13
`define DCFF_PTR_W 14
`define DCFF_DEPTH 14'h2000
`define DCFF_HALF 14'h1000
`define DCFF_SYNC_W 25

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DCFF_CLK_PERIOD_NS 20
`define DCFF_SKEW1_NS 5
`define DCFF_SKEW2_NS 5
`define DCFF_SKEW3_NS 10

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define DCFF_AE_OFFSET_ADDR 12'h000
`define DCFF_AF_OFFSET_ADDR 12'h004
`define DCFF_FLAGS_ADDR 12'h008
`define DCFF_EVENT_ADDR 12'h00c
`define DCFF_MASK_ADDR 12'h010
`define DCFF_AE_OFFSET_RST 14'h007f
`define DCFF_AF_OFFSET_RST 14'h007f
`define DCFF_MASK_RST 6'h00
`define DCFF_LEVEL_LSB 16

// ----------------------------------------------------------------
// event bits
// ----------------------------------------------------------------
`define DCFF_EV_W 6
`define DCFF_EV_FULL 0
`define DCFF_EV_EMPTY 1
`define DCFF_EV_AFULL 2
`define DCFF_EV_AEMPTY 3
`define DCFF_EV_OVERFLOW 4
`define DCFF_EV_UNDERFLOW 5

`endif

// ==== hdl/dcff_pkg.sv ====
`include "dcff_cfg.svh"
`default_nettype none

package dcff_pkg;
    typedef logic [`DCFF_DATA_W-1:0] dcff_word_t;
    typedef logic [`DCFF_PTR_W-1:0] dcff_ptr_t;
    typedef logic [`DCFF_EV_W-1:0] dcff_ev_t;
endpackage : dcff_pkg

`default_nettype wire

// ==== hdl/dcff_pin_sync.sv ====
`include "dcff_cfg.svh"
`default_nettype none

module dcff_pin_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] level_o
);
    // ----------------------------------------------------------------
    // three stages plus an output flop per bit, change taken when stages two and three agree
    // ----------------------------------------------------------------
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        logic s1_reg;
        logic s2_reg;
        logic s3_reg;
        always_ff @(posedge clk_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
            begin
                s1_reg <= 1'b0;
                s2_reg <= 1'b0;
                s3_reg <= 1'b0;
                level_o[i] <= 1'b0;
            end
            else
            begin
                s1_reg <= async_i[i];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
                if (s2_reg == s3_reg)
                begin
                    level_o[i] <= s3_reg;
                end
            end
        end
    end
endmodule : dcff_pin_sync

`default_nettype wire

// ==== hdl/dcff_top.sv ====
// Functional notes
// [R1] full release counts reads one skew earlier
// [R2] empty release counts writes one skew earlier
// [R3] sync almost-empty counts writes three-skew earlier
// [R4] sync almost-full counts reads three-skew earlier
// [R5] after clear outputs low, drive follows enable
// [R6] clocks may run throughout master clear
// [R7] first word read cycle after empty release
// [R8] first-word latency only at the empty boundary
// [R9] almost-empty low at n or fewer words
// [R10] almost-full low at depth minus m words
// [R11] almost-full asserts on qualifying write edge
// [R12] select low registers almost flags, else async
// [R13] sync almost flags update on own clock edges
// [R14] full low when no space, blocks writes
// [R15] empty low when no word, blocks reads
// [R16] chain-out pulses on last physical location
// [R17] producer and consumer qualify on flags
`include "dcff_cfg.svh"
`default_nettype none

module dcff_top (
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic WRITE_CLK_I,
    input wire logic READ_CLK_I,
    input wire logic WRITE_EN_N_I,
    input wire logic READ_EN_N_I,
    input wire logic [17:0] DATA_I,
    input wire logic OUT_EN_N_I,
    input wire logic FLAG_SYNC_SELECT_I,
    input wire logic MASTER_CLEAR_N_I,
    output logic [17:0] DATA_O,
    output logic DATA_OE_O,
    output logic FULL_FLAG_N_O,
    output logic EMPTY_FLAG_N_O,
    output logic ALMOST_FULL_FLAG_N_O,
    output logic ALMOST_EMPTY_FLAG_N_O,
    output logic HALF_FULL_FLAG_N_O,
    output logic WRITE_CHAIN_OUT_N_O,
    output logic READ_CHAIN_OUT_N_O,
    output logic IRQ_O,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O
);
    localparam int SK1 = (`DCFF_SKEW1_NS + `DCFF_CLK_PERIOD_NS - 1) / `DCFF_CLK_PERIOD_NS;
    localparam int SK2 = (`DCFF_SKEW2_NS + `DCFF_CLK_PERIOD_NS - 1) / `DCFF_CLK_PERIOD_NS;
    localparam int SK3 = (`DCFF_SKEW3_NS + `DCFF_CLK_PERIOD_NS - 1) / `DCFF_CLK_PERIOD_NS;
    localparam int D1 = (SK1 < 1) ? 1 : SK1;
    localparam int D2 = (SK2 < 1) ? 1 : SK2;
    localparam int D3 = (SK3 < 1) ? 1 : SK3;
    localparam int HD = (D1 > D3) ? ((D1 > D2) ? D1 : D2) : ((D3 > D2) ? D3 : D2);

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [`DCFF_SYNC_W-1:0] pins;
    logic wclk_f;
    logic rclk_f;
    logic wen_n_f;
    logic ren_n_f;
    dcff_pkg::dcff_word_t din_f;
    logic oe_n_f;
    logic sel_f;
    logic clr_n_f;
    logic wclk_d_reg;
    logic rclk_d_reg;

    dcff_pin_sync #(.W(`DCFF_SYNC_W)) u_sync (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESET_N_I),
        .async_i({WRITE_CLK_I, READ_CLK_I, WRITE_EN_N_I, READ_EN_N_I, DATA_I,
                  OUT_EN_N_I, FLAG_SYNC_SELECT_I, MASTER_CLEAR_N_I}),
        .level_o(pins)
    );
    assign {wclk_f, rclk_f, wen_n_f, ren_n_f, din_f, oe_n_f, sel_f, clr_n_f} = pins;

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            wclk_d_reg <= 1'b0;
            rclk_d_reg <= 1'b0;
        end
        else
        begin
            wclk_d_reg <= wclk_f;
            rclk_d_reg <= rclk_f;
        end
    end

    // clocks keep running during clear; edges are simply ignored
    wire logic clr = !clr_n_f; // [R6]
    wire logic wrise = wclk_f && !wclk_d_reg;
    wire logic rrise = rclk_f && !rclk_d_reg;
    wire logic wr_take = wrise && !wen_n_f && FULL_FLAG_N_O && !clr; // [R14]
    wire logic rd_take = rrise && !ren_n_f && EMPTY_FLAG_N_O && !clr; // [R15] [R17]

    // ----------------------------------------------------------------
    // pointers, skew history and storage
    // ----------------------------------------------------------------
    dcff_pkg::dcff_ptr_t wr_ptr_reg;
    dcff_pkg::dcff_ptr_t rd_ptr_reg;
    dcff_pkg::dcff_ptr_t wr_hist [0:HD-1];
    dcff_pkg::dcff_ptr_t rd_hist [0:HD-1];
    dcff_pkg::dcff_word_t mem [0:(1<<`DCFF_ADDR_W)-1];
    wire dcff_pkg::dcff_ptr_t wr_ptr_next = wr_ptr_reg + dcff_pkg::dcff_ptr_t'(wr_take);
    wire dcff_pkg::dcff_ptr_t rd_ptr_next = rd_ptr_reg + dcff_pkg::dcff_ptr_t'(rd_take);
    wire dcff_pkg::dcff_ptr_t level = wr_ptr_reg - rd_ptr_reg;

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else if (clr)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    for (genvar i = 0; i < HD; i++)
    begin : g_hist
        always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
        begin
            if (!RESET_N_I)
            begin
                wr_hist[i] <= '0;
                rd_hist[i] <= '0;
            end
            else if (clr)
            begin
                wr_hist[i] <= '0;
                rd_hist[i] <= '0;
            end
            else if (i == 0)
            begin
                wr_hist[i] <= wr_ptr_reg;
                rd_hist[i] <= rd_ptr_reg;
            end
            else
            begin
                wr_hist[i] <= wr_hist[(i == 0) ? 0 : i-1];
                rd_hist[i] <= rd_hist[(i == 0) ? 0 : i-1];
            end
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (wr_take)
        begin
            mem[wr_ptr_reg[`DCFF_ADDR_W-1:0]] <= din_f;
        end
    end

    // ----------------------------------------------------------------
    // levels seen by each side after skew
    // ----------------------------------------------------------------
    wire dcff_pkg::dcff_ptr_t lvl_full = wr_ptr_next - rd_hist[D1-1]; // [R1]
    wire dcff_pkg::dcff_ptr_t lvl_empty = wr_hist[D2-1] - rd_ptr_next; // [R2] [R8]
    wire dcff_pkg::dcff_ptr_t lvl_af = wr_ptr_next - rd_hist[D3-1]; // [R4]
    wire dcff_pkg::dcff_ptr_t lvl_ae = wr_hist[D3-1] - rd_ptr_next; // [R3]
    dcff_pkg::dcff_ptr_t ae_off_reg;
    dcff_pkg::dcff_ptr_t af_off_reg;
    wire dcff_pkg::dcff_ptr_t af_thr = `DCFF_DEPTH - af_off_reg;

    // ----------------------------------------------------------------
    // flags
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            FULL_FLAG_N_O <= 1'b1;
            EMPTY_FLAG_N_O <= 1'b0;
        end
        else if (clr)
        begin
            FULL_FLAG_N_O <= 1'b1;
            EMPTY_FLAG_N_O <= 1'b0;
        end
        else
        begin
            if (wrise)
            begin
                FULL_FLAG_N_O <= (lvl_full != `DCFF_DEPTH); // [R14] [R1]
            end
            if (rrise)
            begin
                EMPTY_FLAG_N_O <= (lvl_empty != '0); // [R15] [R2]
            end
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            ALMOST_FULL_FLAG_N_O <= 1'b1;
            ALMOST_EMPTY_FLAG_N_O <= 1'b0;
            HALF_FULL_FLAG_N_O <= 1'b1;
        end
        else if (clr)
        begin
            ALMOST_FULL_FLAG_N_O <= 1'b1;
            ALMOST_EMPTY_FLAG_N_O <= 1'b0;
            HALF_FULL_FLAG_N_O <= 1'b1;
        end
        else
        begin
            HALF_FULL_FLAG_N_O <= !(level > `DCFF_HALF);
            if (sel_f)
            begin
                ALMOST_FULL_FLAG_N_O <= !(level >= af_thr); // [R12] [R10]
                ALMOST_EMPTY_FLAG_N_O <= !(level <= ae_off_reg); // [R12] [R9]
            end
            else
            begin
                if (wrise)
                begin
                    ALMOST_FULL_FLAG_N_O <= !(lvl_af >= af_thr); // [R13] [R11] [R10]
                end
                if (rrise)
                begin
                    ALMOST_EMPTY_FLAG_N_O <= !(lvl_ae <= ae_off_reg); // [R13] [R9]
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // read data, output drive and chain outputs
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            DATA_O <= '0;
            DATA_OE_O <= 1'b0;
            WRITE_CHAIN_OUT_N_O <= 1'b1;
            READ_CHAIN_OUT_N_O <= 1'b1;
        end
        else
        begin
            DATA_OE_O <= !oe_n_f; // [R5]
            if (clr)
            begin
                DATA_O <= '0; // [R5]
                WRITE_CHAIN_OUT_N_O <= 1'b1;
                READ_CHAIN_OUT_N_O <= 1'b1;
            end
            else
            begin
                if (rd_take)
                begin
                    DATA_O <= mem[rd_ptr_reg[`DCFF_ADDR_W-1:0]]; // [R7]
                end
                if (wrise)
                begin
                    WRITE_CHAIN_OUT_N_O <= !(wr_take && &wr_ptr_reg[`DCFF_ADDR_W-1:0]); // [R16]
                end
                if (rrise)
                begin
                    READ_CHAIN_OUT_N_O <= !(rd_take && &rd_ptr_reg[`DCFF_ADDR_W-1:0]); // [R16]
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // events and interrupt
    // ----------------------------------------------------------------
    logic [4:0] flags_d_reg;
    dcff_pkg::dcff_ev_t ev_reg;
    dcff_pkg::dcff_ev_t mask_reg;
    dcff_pkg::dcff_ev_t ev_set;
    wire logic apb_acc = PSEL_I && PENABLE_I && PREADY_O;
    wire logic ev_rd_clr = apb_acc && !PWRITE_I && (PADDR_I == `DCFF_EVENT_ADDR);

    always_comb
    begin
        ev_set = '0;
        ev_set[`DCFF_EV_FULL] = flags_d_reg[0] && !FULL_FLAG_N_O;
        ev_set[`DCFF_EV_EMPTY] = flags_d_reg[1] && !EMPTY_FLAG_N_O;
        ev_set[`DCFF_EV_AFULL] = flags_d_reg[2] && !ALMOST_FULL_FLAG_N_O;
        ev_set[`DCFF_EV_AEMPTY] = flags_d_reg[3] && !ALMOST_EMPTY_FLAG_N_O;
        ev_set[`DCFF_EV_OVERFLOW] = wrise && !wen_n_f && !FULL_FLAG_N_O && !clr;
        ev_set[`DCFF_EV_UNDERFLOW] = rrise && !ren_n_f && !EMPTY_FLAG_N_O && !clr;
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            flags_d_reg <= 5'h15;
            ev_reg <= '0;
            IRQ_O <= 1'b0;
        end
        else
        begin
            flags_d_reg <= {HALF_FULL_FLAG_N_O, ALMOST_EMPTY_FLAG_N_O, ALMOST_FULL_FLAG_N_O,
                            EMPTY_FLAG_N_O, FULL_FLAG_N_O};
            ev_reg <= (ev_rd_clr ? '0 : ev_reg) | ev_set;
            IRQ_O <= |(ev_reg & mask_reg);
        end
    end

    // ----------------------------------------------------------------
    // apb slave, one wait state
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    logic addr_ok;

    always_comb
    begin
        rd_mux = '0;
        addr_ok = 1'b1;
        case (PADDR_I)
            `DCFF_AE_OFFSET_ADDR: rd_mux[`DCFF_PTR_W-1:0] = ae_off_reg;
            `DCFF_AF_OFFSET_ADDR: rd_mux[`DCFF_PTR_W-1:0] = af_off_reg;
            `DCFF_FLAGS_ADDR:
            begin
                rd_mux[4:0] = {HALF_FULL_FLAG_N_O, ALMOST_EMPTY_FLAG_N_O,
                               ALMOST_FULL_FLAG_N_O, EMPTY_FLAG_N_O, FULL_FLAG_N_O};
                rd_mux[`DCFF_LEVEL_LSB +: `DCFF_PTR_W] = level;
            end
            `DCFF_EVENT_ADDR: rd_mux[`DCFF_EV_W-1:0] = ev_reg;
            `DCFF_MASK_ADDR: rd_mux[`DCFF_EV_W-1:0] = mask_reg;
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            PREADY_O <= 1'b0;
            PRDATA_O <= '0;
            PSLVERR_O <= 1'b0;
        end
        else
        begin
            PREADY_O <= PSEL_I && PENABLE_I && !PREADY_O;
            PSLVERR_O <= PSEL_I && PENABLE_I && !PREADY_O && !addr_ok;
            if (PSEL_I && PENABLE_I && !PREADY_O)
            begin
                PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            ae_off_reg <= `DCFF_AE_OFFSET_RST;
            af_off_reg <= `DCFF_AF_OFFSET_RST;
            mask_reg <= `DCFF_MASK_RST;
        end
        else if (apb_acc && PWRITE_I)
        begin
            case (PADDR_I)
                `DCFF_AE_OFFSET_ADDR: ae_off_reg <= PWDATA_I[`DCFF_PTR_W-1:0];
                `DCFF_AF_OFFSET_ADDR: af_off_reg <= PWDATA_I[`DCFF_PTR_W-1:0];
                `DCFF_MASK_ADDR: mask_reg <= PWDATA_I[`DCFF_EV_W-1:0];
                default: mask_reg <= mask_reg;
            endcase
        end
    end
endmodule : dcff_top

`default_nettype wire

// ==== bench/dcff_flag_assertions.sv ====
`default_nettype none
module dcff_flag_checker (
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic WRITE_CLK_I,
    input wire logic READ_CLK_I,
    input wire logic OUT_EN_N_I,
    input wire logic FLAG_SYNC_SELECT_I,
    input wire logic MASTER_CLEAR_N_I,
    input wire logic [17:0] DATA_O,
    input wire logic DATA_OE_O,
    input wire logic FULL_FLAG_N_O,
    input wire logic EMPTY_FLAG_N_O,
    input wire logic ALMOST_FULL_FLAG_N_O,
    input wire logic ALMOST_EMPTY_FLAG_N_O,
    input wire logic HALF_FULL_FLAG_N_O,
    input wire logic WRITE_CHAIN_OUT_N_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    // ----
    // flag and output relations
    // ----
    sequence s_chain_low;
        (!WRITE_CHAIN_OUT_N_O)[*7] ##[1:3] WRITE_CHAIN_OUT_N_O;
    endsequence
    sequence s_oe_steady;
        $stable(OUT_EN_N_I)[*6];
    endsequence
    a_reset_state:
        assert property ($rose(RESET_N_I) |-> !EMPTY_FLAG_N_O && FULL_FLAG_N_O && DATA_O == 18'h0)
        else $error("flags or data wrong after reset");
    a_oe_follows:
        assert property (s_oe_steady |-> DATA_OE_O != OUT_EN_N_I)
        else $error("data drive does not follow enable");
    a_full_af:
        assert property (!FLAG_SYNC_SELECT_I && !FULL_FLAG_N_O |-> !ALMOST_FULL_FLAG_N_O)
        else $error("full without almost full");
    a_empty_ae:
        assert property (!FLAG_SYNC_SELECT_I && !EMPTY_FLAG_N_O |-> !ALMOST_EMPTY_FLAG_N_O)
        else $error("empty without almost empty");
    a_full_half:
        assert property (!FULL_FLAG_N_O |-> !HALF_FULL_FLAG_N_O)
        else $error("full without half full");
    a_full_edge:
        assert property ($changed(FULL_FLAG_N_O) && MASTER_CLEAR_N_I |->
            $past(WRITE_CLK_I, 4) || $past(WRITE_CLK_I, 5) || $past(WRITE_CLK_I, 6))
        else $error("full flag moved without write edge");
    a_empty_edge:
        assert property ($changed(EMPTY_FLAG_N_O) && MASTER_CLEAR_N_I |->
            $past(READ_CLK_I, 4) || $past(READ_CLK_I, 5) || $past(READ_CLK_I, 6))
        else $error("empty flag moved without read edge");
    a_chain_pulse:
        assert property ($fell(WRITE_CHAIN_OUT_N_O) |-> s_chain_low)
        else $error("write chain pulse length wrong");
endmodule : dcff_flag_checker

bind dcff_top dcff_flag_checker i_chk (
    .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .WRITE_CLK_I(WRITE_CLK_I),
    .READ_CLK_I(READ_CLK_I), .OUT_EN_N_I(OUT_EN_N_I), .FLAG_SYNC_SELECT_I(FLAG_SYNC_SELECT_I),
    .MASTER_CLEAR_N_I(MASTER_CLEAR_N_I), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O),
    .FULL_FLAG_N_O(FULL_FLAG_N_O), .EMPTY_FLAG_N_O(EMPTY_FLAG_N_O),
    .ALMOST_FULL_FLAG_N_O(ALMOST_FULL_FLAG_N_O), .ALMOST_EMPTY_FLAG_N_O(ALMOST_EMPTY_FLAG_N_O),
    .HALF_FULL_FLAG_N_O(HALF_FULL_FLAG_N_O), .WRITE_CHAIN_OUT_N_O(WRITE_CHAIN_OUT_N_O)
);
`default_nettype wire

// ==== bench/dcff_link_model.sv ====
`default_nettype none
module dcff_link_model (
    input wire logic clk_i,
    input wire logic wr_go_i,
    input wire logic rd_go_i,
    input wire logic rude_i,
    input wire logic slow_i,
    input wire logic full_n_i,
    input wire logic empty_n_i,
    output logic wclk_o,
    output logic rclk_o,
    output logic wen_n_o,
    output logic ren_n_o,
    output logic [17:0] data_o,
    output int wcnt_o,
    output int rcnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // producer and consumer on free-running clocks
    // ----
    logic [2:0] ph = 3'h0;
    logic alt = 1'b0;
    initial
    begin
        wclk_o = 1'b0;
        rclk_o = 1'b0;
        wen_n_o = 1'b1;
        ren_n_o = 1'b1;
        data_o = 18'h0;
        wcnt_o = 0;
        rcnt_o = 0;
    end
    always @(posedge clk_i)
    begin
        ph <= ph + 3'h1;
        wclk_o <= ph == 3'h7 || ph < 3'h3;
        rclk_o <= ph > 3'h0 && ph < 3'h5;
        if (ph == 3'h7 && !wen_n_o)
            wcnt_o <= wcnt_o + 1;
        if (ph == 3'h1 && !ren_n_o)
            rcnt_o <= rcnt_o + 1;
        if (ph == 3'h5)
        begin
            wen_n_o <= !(wr_go_i && (full_n_i || rude_i));
            data_o <= wr_go_i ? wcnt_o[17:0] : ~data_o;
        end
        if (ph == 3'h7)
        begin
            alt <= !alt;
            ren_n_o <= !(rd_go_i && (empty_n_i || rude_i) && (alt || !slow_i));
        end
    end
endmodule : dcff_link_model
`default_nettype wire

// ==== bench/tb_top.sv ====
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} dcff_row_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic oen_n = 1'b0;
    logic fsel = 1'b0;
    logic mclr_n = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic wr_go = 1'b0;
    logic rd_go = 1'b0;
    logic rude = 1'b0;
    logic slow = 1'b0;
    logic wclk, rclk, wen_n, ren_n, doe, ff_n, ef_n, af_n, ae_n, hf_n, irq, pready, pslverr, rerr;
    logic [17:0] din, dout;
    logic [31:0] prdata, rdat;
    int wcnt, rcnt;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    dcff_row_s rows [12] = '{
        '{1'b0, 12'h000, 32'h0, 32'h7f, 1'b0}, '{1'b0, 12'h004, 32'h0, 32'h7f, 1'b0},
        '{1'b0, 12'h008, 32'h0, 32'h15, 1'b0}, '{1'b0, 12'h010, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h014, 32'h0, 32'h0, 1'b1}, '{1'b1, 12'h014, 32'hffff, 32'h0, 1'b1},
        '{1'b1, 12'h000, 32'h2, 32'h0, 1'b0}, '{1'b0, 12'h000, 32'h0, 32'h2, 1'b0},
        '{1'b1, 12'h004, 32'h1ffc, 32'h0, 1'b0}, '{1'b0, 12'h004, 32'h0, 32'h1ffc, 1'b0},
        '{1'b1, 12'h010, 32'h30, 32'h0, 1'b0}, '{1'b0, 12'h010, 32'h0, 32'h30, 1'b0}};
    always #10 clk = ~clk;
    dcff_top i_dut (
        .REF_CLK_I(clk), .RESET_N_I(rst_n), .WRITE_CLK_I(wclk), .READ_CLK_I(rclk),
        .WRITE_EN_N_I(wen_n), .READ_EN_N_I(ren_n), .DATA_I(din), .OUT_EN_N_I(oen_n),
        .FLAG_SYNC_SELECT_I(fsel), .MASTER_CLEAR_N_I(mclr_n), .DATA_O(dout), .DATA_OE_O(doe),
        .FULL_FLAG_N_O(ff_n), .EMPTY_FLAG_N_O(ef_n), .ALMOST_FULL_FLAG_N_O(af_n),
        .ALMOST_EMPTY_FLAG_N_O(ae_n), .HALF_FULL_FLAG_N_O(hf_n), .WRITE_CHAIN_OUT_N_O(),
        .READ_CHAIN_OUT_N_O(), .IRQ_O(irq), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr));
    dcff_link_model i_link (
        .clk_i(clk), .wr_go_i(wr_go), .rd_go_i(rd_go), .rude_i(rude), .slow_i(slow),
        .full_n_i(ff_n), .empty_n_i(ef_n), .wclk_o(wclk), .rclk_o(rclk), .wen_n_o(wen_n),
        .ren_n_o(ren_n), .data_o(din), .wcnt_o(wcnt), .rcnt_o(rcnt));
    // ----
    // shared tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic flg(input logic [4:0] x);
        chk(32'({hf_n, ae_n, af_n, ef_n, ff_n}), 32'(x));
    endtask : flg
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic link(input logic rd, input int n, input logic r);
        int t;
        t = (rd ? rcnt : wcnt) + n;
        rude <= r;
        rd_go <= rd;
        wr_go <= !rd;
        for (int i = 0; i < n * 8 + 64 && (rd ? rcnt : wcnt) < t; i++)
            @(posedge clk);
        rd_go <= 1'b0;
        wr_go <= 1'b0;
        rude <= 1'b0;
        repeat (16) @(posedge clk);
    endtask : link
    task automatic report_and_stop();
        $display("[tb] checks=%0d errors=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (8) @(posedge clk);
        flg(5'h15);
        chk(32'({doe, irq, dout}), 32'h0);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk(32'(doe), 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                chk(rdat, rows[i].x);
            chk(32'(rerr), 32'(rows[i].e));
        end
        $display("[tb] register rows done");
        link(1'b0, 3, 1'b0);
        flg(5'h1f);
        link(1'b0, 1, 1'b0);
        flg(5'h1b);
        link(1'b1, 1, 1'b0);
        chk(32'(dout), 32'h0);
        flg(5'h1f);
        link(1'b1, 1, 1'b0);
        flg(5'h17);
        slow <= 1'b1;
        link(1'b1, 2, 1'b0);
        slow <= 1'b0;
        chk(32'(dout), 32'h3);
        flg(5'h15);
        chk(32'(irq), 32'h0);
        link(1'b1, 1, 1'b1);
        chk(32'({irq, dout}), 32'h40003);
        apb(1'b0, 12'h00c, 32'h0);
        chk(32'(rdat[5]), 32'h1);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        $display("[tb] flag walk done");
        link(1'b0, 1, 1'b0);
        flg(5'h17);
        fsel <= 1'b1;
        apb(1'b1, 12'h000, 32'h0);
        repeat (4) @(posedge clk);
        flg(5'h1f);
        fsel <= 1'b0;
        $display("[tb] async mode done");
        link(1'b0, 8191, 1'b0);
        flg(5'h0a);
        link(1'b0, 1, 1'b1);
        flg(5'h0a);
        chk(32'(irq), 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        chk(32'(rdat[4]), 32'h1);
        oen_n <= 1'b1;
        mclr_n <= 1'b0;
        repeat (12) @(posedge clk);
        mclr_n <= 1'b1;
        repeat (8) @(posedge clk);
        flg(5'h15);
        chk(32'({doe, dout}), 32'h0);
        $display("[tb] full and clear done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
